// *** inc/amc_pkg.sv ***
// ============================================================
// alert mask, current-sense tempco and loop gain configuration
// constants, register codes and transaction carriers
// assumes the management-bus engine decodes each transfer into byte strobes
// Operation
// [R01] A fault whose mask bit is set never pulls the alert pin, unmasked faults still do; the code still lets a masked fault in status byte 5 pull it.
// [R02] Each mask bit masks the status bit of the same position in the matching status byte; in the code the bits of mask byte 5 mask nothing.
// [R03] The alert mask is seven bytes wide and clears to all zeros at reset.
// [R04] Mask bytes 0..6 map to vout, iout, input, temperature, cml, unused and mfr status.
// [R05] Tempco bits 6:0 hold the copper coefficient in 100 ppm steps, codes 0..127.
// [R06] Tempco bit 7 picks the internal sensor at 0 or the external junction at 1.
// [R07] The host enables external temperature measurement when it picks that source.
// [R08] The sense gain is the 25 degree gain times (1 + coefficient/1e6 x (T - 25)).
// [R09] The tempco register resets to 00h, zero correction with the internal sensor.
// [R10] For inductor resistance sensing the host programs 3900 ppm, code 27h.
// [R11] With a self-compensating power stage the host leaves the coefficient at zero.
// [R12] The loop gain register holds integral gain 31:24, residual 23:16 and gain 15:0.
// [R13] After reset integral gain is 100, residual 90 and loop gain comes from the strap.
// [R14] Mask byte 5 is stored but never affects the alert pin.
// [R15] The four loop gain bytes move as a block, least significant byte first.
package amc_pkg;
  // command codes of the three registers
  localparam logic [7:0] AMC_CMD_ALERT_MASK = 8'hDB;
  localparam logic [7:0] AMC_CMD_TEMPCO     = 8'hDC;
  localparam logic [7:0] AMC_CMD_LOOP_GAIN  = 8'hDF;
  // byte counts
  localparam int AMC_MASK_BYTES = 7;
  localparam int AMC_LOOP_BYTES = 4;
  localparam int AMC_UNUSED_BYTE = 5;
  // mask byte roles
  localparam int AMC_BYTE_VOUT  = 0;
  localparam int AMC_BYTE_IOUT  = 1;
  localparam int AMC_BYTE_INPUT = 2;
  localparam int AMC_BYTE_TEMP  = 3;
  localparam int AMC_BYTE_CML   = 4;
  localparam int AMC_BYTE_MFR   = 6;
  // tempco fields
  localparam int AMC_TC_SRC_BIT = 7;
  localparam int AMC_TC_MSB     = 6;
  localparam logic [7:0] AMC_TC_RESET = 8'h00;
  // tempco arithmetic: code steps of 100 ppm against a 1e6 base
  localparam int AMC_TC_STEP_PPM = 100;
  localparam int AMC_PPM_BASE    = 1000000;
  localparam int AMC_TC_DIVISOR  = AMC_PPM_BASE / AMC_TC_STEP_PPM;
  localparam int AMC_REF_TEMP_C  = 25;
  // loop gain fields and reset values
  localparam int AMC_IGAIN_LSB = 24;
  localparam int AMC_RESID_LSB = 16;
  localparam logic [7:0] AMC_IGAIN_RESET = 8'h64;
  localparam logic [7:0] AMC_RESID_RESET = 8'h5A;
  // strap capture waits for the two-stage synchroniser to fill
  localparam logic [1:0] AMC_STRAP_WAIT = 2'h3;

  // one decoded byte of a management-bus transfer
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] code;
    logic [2:0] idx;
    logic [7:0] data;
  } amc_cmd_t;

  // answer to a read or write byte
  typedef struct packed {
    logic       valid;
    logic       unsupported;
    logic [7:0] data;
  } amc_rsp_t;
endpackage

// *** logic/amc_config_regs.sv ***
// ============================================================
// alert mask, tempco and loop gain register bank with alert gating
// and temperature-compensated sense gain
// assumes status, temperatures and gain come from logic on clk,
// the strap code arrives from a pin
`timescale 1ns/100ps
`default_nettype none
module amc_config_regs #(
  parameter int GAIN_W      = 16,
  parameter int TEMP_W      = 12,
  parameter int STRAP_W     = 4,
  parameter logic [15:0] STRAP_BASE = 16'h0064,
  parameter logic [15:0] STRAP_STEP = 16'h0064
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // command port from the management-bus engine
  input  wire amc_pkg::amc_cmd_t    cmd,
  output      amc_pkg::amc_rsp_t    rsp,
  // fault status, seven bytes
  input  wire logic [55:0]          fault_status,
  // alert pin, open drain, active low
  input  wire logic                 alert_out_pin_in,
  output      logic                 alert_out_pin_out,
  output      logic                 alert_out_pin_oe,
  // temperatures in whole degrees, signed
  input  wire logic signed [TEMP_W-1:0] temp_internal,
  input  wire logic signed [TEMP_W-1:0] temp_external,
  // strap pin code
  input  wire logic [STRAP_W-1:0]   config_strap_one,
  // current sense gain
  input  wire logic [GAIN_W-1:0]    sense_gain_25c,
  output      logic [GAIN_W-1:0]    sense_gain_comp,
  // loop settings to the modulator
  output      logic [31:0]          loop_gain_config_q,
  output      logic [7:0]           sense_temp_coefficient_q
);
  import amc_pkg::*;

  // ============================================================
  // functions
  function automatic logic [15:0] strap_gain(input logic [STRAP_W-1:0] code);
    logic [31:0] g;
    g = 32'(STRAP_BASE) + 32'(code) * 32'(STRAP_STEP);
    return g[15:0];
  endfunction

  function automatic logic [7:0] pick_byte(input logic [63:0] word, input logic [2:0] idx);
    return word[{idx, 3'h0} +: 8];
  endfunction

  // ============================================================
  // registers
  logic [55:0] alert_fault_mask_reg, alert_fault_mask_next;
  logic [7:0]  tempco_reg, tempco_next;
  logic [31:0] loop_gain_reg, loop_gain_next;
  logic [1:0]  strap_wait_reg, strap_wait_next;
  logic        strap_pend_reg, strap_pend_next;
  logic [STRAP_W-1:0] strap_s1_reg, strap_s2_reg;
  amc_rsp_t    rsp_reg, rsp_next;

  logic hit_mask, hit_tc, hit_lg;
  assign hit_mask = cmd.code == AMC_CMD_ALERT_MASK && 32'(cmd.idx) < AMC_MASK_BYTES;
  assign hit_tc   = cmd.code == AMC_CMD_TEMPCO && cmd.idx == 3'h0;
  assign hit_lg   = cmd.code == AMC_CMD_LOOP_GAIN && 32'(cmd.idx) < AMC_LOOP_BYTES;

  always_comb
  begin
    alert_fault_mask_next = alert_fault_mask_reg;
    tempco_next           = tempco_reg;
    loop_gain_next        = loop_gain_reg;
    strap_wait_next       = strap_wait_reg;
    strap_pend_next       = strap_pend_reg;
    rsp_next              = '0;
    if (cmd.wr)
    begin
      // [R03] seven mask bytes
      if (hit_mask)
        alert_fault_mask_next[{cmd.idx, 3'h0} +: 8] = cmd.data;
      // [R05] coefficient and source in one byte
      if (hit_tc)
        tempco_next = cmd.data;
      // [R12] [R15] byte 0 is the least significant, field layout follows bytes
      if (hit_lg)
        loop_gain_next[{cmd.idx[1:0], 3'h0} +: 8] = cmd.data;
    end
    if (cmd.wr || cmd.rd)
    begin
      rsp_next.valid       = 1'b1;
      rsp_next.unsupported = !(hit_mask || hit_tc || hit_lg);
      if (cmd.rd)
      begin
        // [R15] reads walk the same byte order
        if (hit_mask)
          rsp_next.data = pick_byte({8'h00, alert_fault_mask_reg}, cmd.idx);
        else if (hit_tc)
          rsp_next.data = tempco_reg;
        else if (hit_lg)
          rsp_next.data = pick_byte({32'h0, loop_gain_reg}, cmd.idx);
      end
    end
    // strap value is caught once the synchroniser holds a settled code;
    // it replaces what the host wrote to bytes 0 and 1 since reset, a write in that same cycle included
    if (strap_pend_reg)
    begin
      if (strap_wait_reg == AMC_STRAP_WAIT)
      begin
        // [R13] loop gain field from the strap
        loop_gain_next[15:0] = strap_gain(strap_s2_reg);
        strap_pend_next      = 1'b0;
      end
      else
        strap_wait_next = strap_wait_reg + 2'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    strap_s1_reg <= config_strap_one;
    strap_s2_reg <= strap_s1_reg;
    if (sys_rst)
    begin
      // [R03] nothing masked after reset
      alert_fault_mask_reg <= '0;
      // [R09] zero correction, internal sensor
      tempco_reg           <= AMC_TC_RESET;
      // [R13] integral gain and residual defaults
      loop_gain_reg        <= {AMC_IGAIN_RESET, AMC_RESID_RESET, 16'h0000};
      strap_wait_reg       <= 2'h0;
      strap_pend_reg       <= 1'b1;
      rsp_reg              <= '0;
    end
    else
    begin
      alert_fault_mask_reg <= alert_fault_mask_next;
      tempco_reg           <= tempco_next;
      loop_gain_reg        <= loop_gain_next;
      strap_wait_reg       <= strap_wait_next;
      strap_pend_reg       <= strap_pend_next;
      rsp_reg              <= rsp_next;
    end
  end

  assign rsp                      = rsp_reg;
  assign loop_gain_config_q       = loop_gain_reg;
  assign sense_temp_coefficient_q = tempco_reg;

  // ============================================================
  // alert gating
  logic [55:0] eff_mask;
  logic        alert_req;
  always_comb
  begin
    eff_mask = alert_fault_mask_reg;
    // [R14] unused byte never gates anything
    eff_mask[AMC_UNUSED_BYTE*8 +: 8] = 8'h00;
  end
  // [R04] byte n of the mask faces status byte n
  // [R01] [R02] bitwise mask against the same status position
  assign alert_req         = |(fault_status & ~eff_mask);
  assign alert_out_pin_out = 1'b0;
  assign alert_out_pin_oe  = alert_req;

  // ============================================================
  // tempco sense gain
  logic signed [TEMP_W-1:0] sel_temp;
  logic signed [TEMP_W:0]   delta;
  logic signed [GAIN_W+TEMP_W+9:0] corr, comp;
  logic [GAIN_W-1:0]        comp_next, comp_reg;
  always_comb
  begin
    // [R06] source select
    sel_temp = tempco_reg[AMC_TC_SRC_BIT] ? temp_external : temp_internal;
    // [R08] gain25 * (1 + tc*100e-6*(T-25))
    delta = (TEMP_W+1)'(sel_temp) - (TEMP_W+1)'(AMC_REF_TEMP_C);
    corr  = $signed({1'b0, sense_gain_25c}) * $signed({1'b0, tempco_reg[AMC_TC_MSB:0]})
            * delta;
    comp  = $signed({1'b0, sense_gain_25c}) + corr / AMC_TC_DIVISOR;
    if (comp < 0)
      comp_next = '0;
    else if (comp > $signed({1'b0, {GAIN_W{1'b1}}}))
      comp_next = '1;
    else
      comp_next = comp[GAIN_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      comp_reg <= '0;
    else
      comp_reg <= comp_next;
  end
  assign sense_gain_comp = comp_reg;

  // ============================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  alert_mask_a: assert property ((fault_status & ~alert_fault_mask_reg) == 56'h0 // [R01]
    && fault_status[AMC_UNUSED_BYTE*8 +: 8] == 8'h00 |-> !alert_out_pin_oe)
    else $error("alert driven by masked fault only");
  mask_bit_map_a: assert property ((cmd.wr && hit_mask) |=> // [R02]
    pick_byte({8'h00, alert_fault_mask_reg}, $past(cmd.idx)) == $past(cmd.data))
    else $error("mask byte not stored at its index");
  mask_reset_a: assert property (disable iff (1'b0) $past(sys_rst) |-> // [R03]
    alert_fault_mask_reg == 56'h0)
    else $error("mask not cleared by reset");
  status_group_a: assert property ((fault_status[AMC_BYTE_TEMP*8 +: 8] // [R04]
    & ~alert_fault_mask_reg[AMC_BYTE_TEMP*8 +: 8]) != 8'h00 |-> alert_out_pin_oe)
    else $error("temperature fault lost");
  byte5_free_a: assert property ((fault_status[AMC_UNUSED_BYTE*8 +: 8] != 8'h00) // [R14]
    |-> alert_out_pin_oe)
    else $error("unused mask byte gated alert");
  src_select_a: assert property (tempco_reg[AMC_TC_SRC_BIT] |-> // [R06]
    sel_temp == temp_external)
    else $error("wrong temperature source");
  tc_reset_a: assert property (disable iff (1'b0) $past(sys_rst) |-> // [R09]
    tempco_reg == AMC_TC_RESET)
    else $error("tempco reset value wrong");
  zero_tc_gain_a: assert property ((tempco_reg[AMC_TC_MSB:0] == 7'h00) |=> // [R08]
    sense_gain_comp == $past(sense_gain_25c))
    else $error("zero coefficient altered gain");
  gain_default_a: assert property (disable iff (1'b0) $past(sys_rst) |-> // [R13]
    loop_gain_reg[31:AMC_IGAIN_LSB] == 8'h64 && loop_gain_reg[23:AMC_RESID_LSB] == 8'h5A)
    else $error("loop gain defaults wrong");
  strap_load_a: assert property ((strap_pend_reg && strap_wait_reg == AMC_STRAP_WAIT) // [R13]
    |=> loop_gain_reg[15:0] == strap_gain($past(strap_s2_reg)) && !strap_pend_reg)
    else $error("strap gain not loaded");
  lsb_first_a: assert property ((cmd.rd && hit_lg && cmd.idx == 3'h0) |=> // [R15]
    rsp.valid && rsp.data == loop_gain_reg[7:0])
    else $error("loop gain byte order wrong");
  field_layout_a: assert property ((cmd.wr && hit_lg && cmd.idx == 3'h3 // [R12]
    && !strap_pend_reg) |=> loop_gain_config_q[31:AMC_IGAIN_LSB] == $past(cmd.data))
    else $error("integral gain field misplaced");
endmodule
`default_nettype wire

// *** bench/amc_host_model.sv ***
// host model: issues one management-bus byte per call
// assumes the bank answers one cycle after each strobe
`timescale 1ns/100ps
`default_nettype none
module amc_host_model (
  // clock
  input  wire logic              clk,
  // byte port
  output var  amc_pkg::amc_cmd_t cmd,
  input  wire amc_pkg::amc_rsp_t rsp
);
  import amc_pkg::*;
  // ============================================================
  // byte transfer
  // blocks go index 0 first
  task automatic xfer(input logic w, input logic [7:0] c, input logic [2:0] i,
                      input logic [7:0] d, output amc_rsp_t r);
    @(posedge clk);
    #1;
    cmd = '{wr: w, rd: !w, code: c, idx: i, data: d};
    @(posedge clk);
    #1;
    r = rsp;
    // released data is inverted so a stale byte never looks valid
    cmd = '{wr: 1'b0, rd: 1'b0, code: ~c, idx: ~i, data: ~d};
  endtask
  initial cmd = '{default: '0};
endmodule
`default_nettype wire

// *** bench/tb_alert_mask_tempco_loop_cfg.sv ***
// testbench: bank driven by the host model, checked against a queue-free model
// assumes default parameter widths of the bank
`timescale 1ns/100ps
`default_nettype none
module tb_alert_mask_tempco_loop_cfg;
  import amc_pkg::*;
  localparam logic [15:0] SB = 16'h0064;
  logic clk, sys_rst, alert_oe, alert_out;
  amc_cmd_t cmd;
  amc_rsp_t rsp, r;
  logic [55:0] fault_status, m_mask;
  logic signed [11:0] t_int, t_ext;
  logic [3:0] strap;
  logic [15:0] g25, gcomp;
  logic [31:0] loop_q, m_loop;
  logic [7:0] tc_q, m_tc;
  logic [7:0] tcv [6];
  int num_errors, n_checks, cyc, b, seed;
  amc_config_regs #(.STRAP_BASE(SB), .STRAP_STEP(SB)) DUT (.clk(clk), .sys_rst(sys_rst),
    .cmd(cmd), .rsp(rsp), .fault_status(fault_status), .alert_out_pin_in(~alert_oe),
    .alert_out_pin_out(alert_out), .alert_out_pin_oe(alert_oe), .temp_internal(t_int),
    .temp_external(t_ext), .config_strap_one(strap), .sense_gain_25c(g25),
    .sense_gain_comp(gcomp), .loop_gain_config_q(loop_q), .sense_temp_coefficient_q(tc_q));
  amc_host_model HOST (.clk(clk), .cmd(cmd), .rsp(rsp));
  // ============================================================
  // compare and report
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [7:0] mbyte(input logic [7:0] c, input logic [2:0] i);
    if (c == AMC_CMD_ALERT_MASK)
      return m_mask[i*8+:8];
    if (c == AMC_CMD_TEMPCO)
      return m_tc;
    return m_loop[i[1:0]*8+:8];
  endfunction
  task automatic rd(input logic [7:0] c, input logic [2:0] i);
    HOST.xfer(1'b0, c, i, 8'h00, r);
    chk({r.valid, r.unsupported, r.data}, {2'b10, mbyte(c, i)});
  endtask
  task automatic wr(input logic [7:0] c, input logic [2:0] i, input logic [7:0] d);
    HOST.xfer(1'b1, c, i, d, r);
    if (c == AMC_CMD_ALERT_MASK)
      m_mask[i*8+:8] = d;
    else if (c == AMC_CMD_TEMPCO)
      m_tc = d;
    else
      m_loop[i[1:0]*8+:8] = d;
    chk({r.valid, r.unsupported, r.data}, 10'h200);
  endtask
  task automatic bad(input logic [7:0] c, input logic [2:0] i);
    HOST.xfer(1'b1, c, i, 8'(i + 8'h5A), r);
    chk({r.valid, r.unsupported, r.data}, 10'h300);
  endtask
  // gain model: signed integers so the product keeps its sign
  function automatic logic [15:0] comp_exp();
    longint g, c, t, v;
    g = g25;
    c = m_tc[6:0];
    t = m_tc[AMC_TC_SRC_BIT] ? t_ext : t_int;
    v = g + (g * c * (t - 25)) / 10000;
    return (v < 0) ? 16'h0000 : (v > 65535) ? 16'hFFFF : 16'(v);
  endfunction
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      give_verdict();
    end
  end
  // ============================================================
  // main sequence
  initial
  begin
    seed = $urandom(32'h824A05D4);
    tcv = '{8'h00, 8'h27, 8'hA7, 8'h7F, 8'hFF, 8'h00};
    tcv[5] = 8'($urandom);
    sys_rst = 1'b1;
    fault_status = '0;
    t_int = '0;
    t_ext = '0;
    g25 = '0;
    strap = 4'($urandom);
    m_mask = '0;
    m_tc = AMC_TC_RESET;
    m_loop = {8'h64, 8'h5A, SB + 16'(strap) * SB};
    repeat (8) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (8) @(posedge clk);
    #1 chk(loop_q, m_loop);
    chk(tc_q, m_tc);
    for (int i = 0; i < 4; i++) rd(AMC_CMD_LOOP_GAIN, 3'(i));
    repeat (20)
    begin
      for (int i = 0; i < 7; i++) wr(AMC_CMD_ALERT_MASK, 3'(i), 8'($urandom));
      for (int i = 0; i < 7; i++) rd(AMC_CMD_ALERT_MASK, 3'(i));
      repeat (8)
      begin
        b = $urandom % 56;
        @(posedge clk);
        #1 fault_status = 56'h1 << b;
        #1 chk(alert_oe, !m_mask[b] || (b / 8 == AMC_UNUSED_BYTE));
        chk(alert_out, 1'b0);
      end
    end
    foreach (tcv[k])
    begin
      // with bit 7 set the host has enabled external measurement elsewhere
      wr(AMC_CMD_TEMPCO, 3'h0, tcv[k]);
      rd(AMC_CMD_TEMPCO, 3'h0);
      chk(tc_q, m_tc);
      repeat (6)
      begin
        g25 = 16'($urandom);
        t_int = 12'($urandom % 200) - 12'h028;
        t_ext = 12'($urandom % 200) - 12'h028;
        repeat (2) @(posedge clk);
        #1 chk(gcomp, comp_exp());
      end
    end
    for (int i = 0; i < 4; i++) wr(AMC_CMD_LOOP_GAIN, 3'(i), 8'($urandom));
    chk(loop_q, m_loop);
    for (int i = 0; i < 4; i++) rd(AMC_CMD_LOOP_GAIN, 3'(i));
    bad(AMC_CMD_ALERT_MASK, 3'h7);
    bad(AMC_CMD_TEMPCO, 3'h1);
    bad(AMC_CMD_LOOP_GAIN, 3'h4);
    bad(8'h00, 3'h0);
    chk({loop_q, tc_q}, {m_loop, m_tc});
    for (int i = 0; i < 7; i++) rd(AMC_CMD_ALERT_MASK, 3'(i));
    // reset in mid-run clears what the host wrote
    @(posedge clk);
    #1 sys_rst = 1'b1;
    repeat (8) @(posedge clk);
    #1 sys_rst = 1'b0;
    m_mask = '0;
    m_tc = 8'h00;
    m_loop = {8'h64, 8'h5A, SB + 16'(strap) * SB};
    repeat (8) @(posedge clk);
    #1 chk({loop_q, tc_q}, {m_loop, m_tc});
    for (int i = 0; i < 7; i++) rd(AMC_CMD_ALERT_MASK, 3'(i));
    give_verdict();
  end
endmodule
`default_nettype wire
